// >>> logic/drc_ctrl.sv
// host-side controller: power-up, access cycles, counter refresh and self-refresh
`timescale 1ns/100ps
`default_nettype none
`include "drc_defs.svh"
module drc_ctrl (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            req_valid,
  input  wire drc_pkg::drc_req_type req,
  output logic                 req_ready,
  output logic                 rd_valid,
  output logic                 rd_data,
  output logic                 init_done,
  input  wire logic            self_refresh_en,
  output logic                 self_refresh_active,
  input  wire logic            mem_data_in,
  output drc_pkg::drc_pins_type pins
);
  import drc_pkg::*;

  drc_state_type         state_reg, state_next;
  drc_pins_type          pins_reg, pins_next;
  logic [3:0]            init_cnt_reg, init_cnt_next;
  logic [9:0]            col_reg, col_next;
  logic [`DRC_CNT_W-1:0] ref_cnt_reg, ref_cnt_next;
  logic                  ref_due_reg, ref_due_next;
  logic                  is_read_reg, is_read_next;
  logic                  rd_valid_reg, rd_valid_next;
  logic                  rd_data_reg, rd_data_next;
  logic                  ready_reg, ready_next;
  logic                  init_done_reg, init_done_next;
  logic                  self_reg, self_next;
  logic                  din_meta_reg, din_sync_reg;
  logic                  tload;
  logic [`DRC_CNT_W-1:0] tval;
  logic                  tdone;

  drc_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (tload),
    .value   (tval),
    .done    (tdone)
  );

  // read data arrives from a pin, so it is synchronised before capture
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      din_meta_reg <= 1'b0;
      din_sync_reg <= 1'b0;
    end else begin
      din_meta_reg <= mem_data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  always_comb begin
    state_next     = state_reg;
    pins_next      = pins_reg;
    init_cnt_next  = init_cnt_reg;
    ref_due_next   = ref_due_reg;
    is_read_next   = is_read_reg;
    rd_valid_next  = 1'b0;
    rd_data_next   = rd_data_reg;
    ready_next     = 1'b0;
    init_done_next = init_done_reg;
    self_next      = self_reg;
    tload          = 1'b0;
    tval           = '0;
    col_next       = col_reg;
    unique case (state_reg)
      ST_PWRUP: begin
        pins_next.row_strobe_n          = 1'b1;
        pins_next.col_strobe_n          = 1'b1;
        pins_next.self_refresh_request_n = 1'b1;
        // the timer leaves reset at zero, so the first cycle arms the pause before done is trusted
        if (init_cnt_reg == 4'h0) begin
          init_cnt_next = 4'h1;
          tload = 1'b1;
          tval  = `DRC_CNT_W'(`DRC_PWRUP_CYC - 1);
        end else if (tdone) begin
          state_next = ST_INIT;
          init_cnt_next = 4'h0;
          pins_next.row_strobe_n = 1'b0;
          tload = 1'b1;
          tval  = `DRC_CNT_W'(`DRC_ROW_LOW_CYC - 1);
        end
      end
      ST_INIT: begin
        // eight plain row-strobe cycles with the column strobe kept high
        if (tdone) begin
          tload = 1'b1;
          if (!pins_reg.row_strobe_n) begin
            pins_next.row_strobe_n = 1'b1;
            init_cnt_next = init_cnt_reg + 1'b1;
            tval = `DRC_CNT_W'(`DRC_ROW_HIGH_CYC - 1);
          end else if (init_cnt_reg == 4'(`DRC_INIT_CYCLES)) begin
            state_next = ST_IDLE;
            init_done_next = 1'b1;
          end else begin
            pins_next.row_strobe_n = 1'b0;
            tval = `DRC_CNT_W'(`DRC_ROW_LOW_CYC - 1);
          end
        end
      end
      ST_IDLE: begin
        if (self_refresh_en) begin
          state_next = ST_SELF;
          self_next  = 1'b1;
          pins_next.self_refresh_request_n = 1'b0;
          tload = 1'b1;
          tval  = `DRC_CNT_W'(`DRC_ROW_HIGH_CYC - 1);
        end else if (ref_due_reg) begin
          // accesses wait while a refresh runs
          state_next = ST_CBR;
          ref_due_next = 1'b0;
          pins_next.col_strobe_n = 1'b0;
          tload = 1'b1;
          tval  = `DRC_CNT_W'(`DRC_CSR_CYC);
        end else if (req_valid) begin
          ready_next = 1'b1;
          state_next = ST_ROWLO;
          is_read_next = !req.write;
          pins_next.addr = req.row;
          col_next = req.col;
          pins_next.write_strobe_n = !req.write;
          pins_next.data_out = req.data;
          pins_next.row_strobe_n = 1'b0;
          tload = 1'b1;
          tval  = `DRC_CNT_W'(`DRC_RCD_CYC - 1);
        end
      end
      ST_ROWLO: begin
        // column strobe falls at the least row-to-column delay, far inside its maximum
        if (tdone) begin
          state_next = ST_COLLO;
          pins_next.addr = col_reg;
          pins_next.col_strobe_n = 1'b0;
          tload = 1'b1;
          tval  = `DRC_CNT_W'(`DRC_ROW_LOW_CYC - `DRC_RCD_CYC - 1);
        end
      end
      ST_COLLO: begin
        if (tdone) begin
          state_next = ST_HOLD;
          if (is_read_reg) begin
            rd_valid_next = 1'b1;
            rd_data_next  = din_sync_reg;
          end
          pins_next.row_strobe_n = 1'b1;
          pins_next.col_strobe_n = 1'b1;
          tload = 1'b1;
          tval  = `DRC_CNT_W'(`DRC_RRH_CYC - 1);
        end
      end
      ST_HOLD: begin
        if (tdone) begin
          state_next = ST_PRECH;
          pins_next.write_strobe_n = 1'b1;
          tload = 1'b1;
          tval  = `DRC_CNT_W'(`DRC_ROW_HIGH_CYC - `DRC_RRH_CYC - 1);
        end
      end
      ST_PRECH: begin
        // precharge covers the column-high to row-low interval too
        if (tdone) begin
          state_next = ST_IDLE;
        end
      end
      ST_CBR: begin
        if (tdone) begin
          tload = 1'b1;
          if (pins_reg.row_strobe_n) begin
            pins_next.row_strobe_n = 1'b0;
            tval = `DRC_CNT_W'(`DRC_ROW_LOW_CYC - 1);
          end else begin
            pins_next.row_strobe_n = 1'b1;
            pins_next.col_strobe_n = 1'b1;
            state_next = ST_PRECH;
            tval = `DRC_CNT_W'(`DRC_ROW_HIGH_CYC + `DRC_CRP_CYC - 1);
          end
        end
      end
      ST_SELF: begin
        // fixed period meets the tightest maximum of every temperature grade
        if (tdone) begin
          tload = 1'b1;
          if (pins_reg.row_strobe_n) begin
            pins_next.row_strobe_n = 1'b0;
            tval = `DRC_CNT_W'(`DRC_SELF_LOW_CYC - 1);
          end else begin
            pins_next.row_strobe_n = 1'b1;
            tval = `DRC_CNT_W'(`DRC_ROW_HIGH_CYC - 1);
            if (!self_refresh_en) begin
              state_next = ST_SELFX;
              pins_next.self_refresh_request_n = 1'b1;
            end
          end
        end
      end
      ST_SELFX: begin
        if (tdone) begin
          state_next = ST_IDLE;
          self_next  = 1'b0;
          ref_due_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_PWRUP;
      end
    endcase
    // one refresh every 32 ms / 512, rounded down so the deadline is kept
    ref_cnt_next = ref_cnt_reg - 1'b1;
    if (ref_cnt_reg == '0) begin
      ref_cnt_next = `DRC_CNT_W'(`DRC_REF_INTERVAL - 1);
      // placed after the state decode so a new request wins over a same-cycle clear
      ref_due_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg     <= ST_PWRUP;
      pins_reg      <= '{1'b1, 1'b1, 1'b1, 1'b1, 10'h000, 1'b0};
      init_cnt_reg  <= 4'h0;
      col_reg       <= 10'h000;
      ref_cnt_reg   <= `DRC_CNT_W'(`DRC_REF_INTERVAL - 1);
      ref_due_reg   <= 1'b0;
      is_read_reg   <= 1'b0;
      rd_valid_reg  <= 1'b0;
      rd_data_reg   <= 1'b0;
      ready_reg     <= 1'b0;
      init_done_reg <= 1'b0;
      self_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      pins_reg      <= pins_next;
      init_cnt_reg  <= init_cnt_next;
      col_reg       <= col_next;
      ref_cnt_reg   <= ref_cnt_next;
      ref_due_reg   <= ref_due_next;
      is_read_reg   <= is_read_next;
      rd_valid_reg  <= rd_valid_next;
      rd_data_reg   <= rd_data_next;
      ready_reg     <= ready_next;
      init_done_reg <= init_done_next;
      self_reg      <= self_next;
    end
  end

  assign pins                = pins_reg;
  assign req_ready           = ready_reg;
  assign rd_valid            = rd_valid_reg;
  assign rd_data             = rd_data_reg;
  assign init_done           = init_done_reg;
  assign self_refresh_active = self_reg;
endmodule : drc_ctrl
`default_nettype wire

// >>> logic/drc_defs.svh
// timing constants and rule overview for the dram refresh and access controller
// Overview of operation
// - a counter refresh starts with the column strobe low before the row strobe falls and held low after.
// - a row-only refresh keeps the column strobe high while the row strobe latches a row address.
// - all 512 combinations of the lower nine address bits must be refreshed within every 32 ms.
// - in self-refresh the row strobe must cycle at no less than the minimum rate for the temperature grade.
// - in self-refresh the row strobe cycle period must not exceed its temperature-dependent maximum.
// - in self-refresh each row strobe high phase lasts at least 390 ns and each cycle at least 1000 ns.
// - after power-up wait at least 100 us, then issue eight row strobe cycles before normal use.
// - during the power-up pause row strobe, column strobe and self-refresh request stay high.
// - in a read the write strobe stays high at least 75 ns after the row strobe rises.
// - at least 30 ns of column-high to row-low precharge precede every new cycle.
// - write strobe high selects a read and low selects a write.
// - ten row bits latch on the falling row strobe, then ten column bits on the falling column strobe.
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_CLK_NS          20
`define DRC_CYC_MIN(ns)     (((ns) + `DRC_CLK_NS - 1) / `DRC_CLK_NS)
`define DRC_CYC_MAX(ns)     ((ns) / `DRC_CLK_NS)
`define DRC_PWRUP_NS        100000
`define DRC_PWRUP_CYC       `DRC_CYC_MIN(`DRC_PWRUP_NS)
`define DRC_INIT_CYCLES     8
`define DRC_ROW_LOW_NS      600
`define DRC_ROW_LOW_CYC     `DRC_CYC_MIN(`DRC_ROW_LOW_NS)
`define DRC_ROW_HIGH_NS     390
`define DRC_ROW_HIGH_CYC    `DRC_CYC_MIN(`DRC_ROW_HIGH_NS)
`define DRC_RCD_NS          150
`define DRC_RCD_CYC         `DRC_CYC_MIN(`DRC_RCD_NS)
`define DRC_CSR_NS          30
`define DRC_CSR_CYC         `DRC_CYC_MIN(`DRC_CSR_NS)
`define DRC_CRP_NS          30
`define DRC_CRP_CYC         `DRC_CYC_MIN(`DRC_CRP_NS)
`define DRC_RRH_NS          75
`define DRC_RRH_CYC         `DRC_CYC_MIN(`DRC_RRH_NS)
`define DRC_SELF_CYCLE_NS   5000
`define DRC_SELF_CYCLE_CYC  `DRC_CYC_MAX(`DRC_SELF_CYCLE_NS)
`define DRC_SELF_LOW_CYC    (`DRC_SELF_CYCLE_CYC - `DRC_ROW_HIGH_CYC)
`define DRC_REF_PERIOD_NS   32000000
`define DRC_REF_ROWS        512
`define DRC_REF_INTERVAL    (`DRC_CYC_MAX(`DRC_REF_PERIOD_NS) / `DRC_REF_ROWS)
`define DRC_ADDR_W          10
`define DRC_CNT_W           17
`endif

// >>> logic/drc_pkg.sv
// types for the dram refresh and access controller
`default_nettype none
package drc_pkg;
  typedef struct packed {
    logic       write;
    logic [9:0] row;
    logic [9:0] col;
    logic       data;
  } drc_req_type;
  typedef struct packed {
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_strobe_n;
    logic self_refresh_request_n;
    logic [9:0] addr;
    logic data_out;
  } drc_pins_type;
  typedef enum logic [9:0] {
    ST_PWRUP  = 10'b00_0000_0001,
    ST_INIT   = 10'b00_0000_0010,
    ST_IDLE   = 10'b00_0000_0100,
    ST_ROWLO  = 10'b00_0000_1000,
    ST_COLLO  = 10'b00_0001_0000,
    ST_HOLD   = 10'b00_0010_0000,
    ST_PRECH  = 10'b00_0100_0000,
    ST_CBR    = 10'b00_1000_0000,
    ST_SELF   = 10'b01_0000_0000,
    ST_SELFX  = 10'b10_0000_0000
  } drc_state_type;
endpackage : drc_pkg
`default_nettype wire

// >>> logic/drc_timer.sv
// down-counting interval timer with load and done flag
`timescale 1ns/100ps
`default_nettype none
`include "drc_defs.svh"
module drc_timer (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 load,
  input  wire logic [`DRC_CNT_W-1:0] value,
  output logic                      done
);
  logic [`DRC_CNT_W-1:0] count_reg;
  logic [`DRC_CNT_W-1:0] count_next;
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = value;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  // done ignores load, since the caller derives load from done and would otherwise loop
  assign done = (count_reg == '0);
endmodule : drc_timer
`default_nettype wire

// >>> testbench/drc_ctrl_chk.sv
// pin sequencing checker for the dram controller
`timescale 1ns/100ps
`default_nettype none
module drc_ctrl_chk (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  init_done,
  input wire logic                  req_ready,
  input wire logic                  self_refresh_active,
  input wire drc_pkg::drc_pins_type pins
);
  import drc_pkg::*;
  logic [12:0] up_reg, up_next;
  logic [11:0] hi_reg, hi_next, gap_reg, gap_next, sf_reg, sf_next;
  logic [3:0]  nf_reg, nf_next;
  logic        fall;
  // counters other than sf_reg saturate so a long idle cannot wrap into a false pass
  always_comb begin
    fall = !pins.row_strobe_n && hi_reg != 12'h000;
    up_next = up_reg + {12'h000, up_reg != 13'h1FFF};
    hi_next = pins.row_strobe_n ? hi_reg + {11'h000, hi_reg != 12'hFFF} : 12'h000;
    gap_next = fall ? 12'h000 : gap_reg + {11'h000, gap_reg != 12'hFFF};
    sf_next = (fall || pins.self_refresh_request_n) ? 12'h000 : sf_reg + 12'h001;
    nf_next = nf_reg + {3'h0, fall && nf_reg != 4'hF};
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {up_reg, hi_reg, gap_reg, sf_reg, nf_reg} <= '0;
    end else begin
      {up_reg, hi_reg, gap_reg, sf_reg, nf_reg} <= {up_next, hi_next, gap_next, sf_next, nf_next};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  pause_quiet_a: assert property (
    up_reg < 13'h1388 |-> pins.row_strobe_n && pins.col_strobe_n && pins.self_refresh_request_n)
    else $error("strobe moved during power-up pause");
  init_eight_a: assert property ($rose(init_done) |-> nf_reg >= 4'h8)
    else $error("init done before eight row cycles");
  crp_gap_a: assert property (
    $fell(pins.row_strobe_n) && pins.col_strobe_n |-> $past(pins.col_strobe_n) && $past(pins.col_strobe_n, 2))
    else $error("column precharge too short");
  cbr_order_a: assert property (
    $fell(pins.row_strobe_n) && !pins.col_strobe_n |->
    (!$past(pins.col_strobe_n) && !$past(pins.col_strobe_n, 2)) ##1 (!pins.col_strobe_n)[*5])
    else $error("column strobe order wrong in counter refresh");
  read_hold_a: assert property (
    $rose(pins.row_strobe_n) && pins.write_strobe_n |-> pins.write_strobe_n[*4])
    else $error("write strobe fell too soon after read");
  row_prech_a: assert property ($fell(pins.row_strobe_n) |-> hi_reg >= 12'h014)
    else $error("row precharge too short");
  row_cycle_a: assert property ($fell(pins.row_strobe_n) |-> gap_reg >= 12'h031)
    else $error("row cycle too short");
  self_rate_a: assert property (!pins.self_refresh_request_n |-> sf_reg < 12'h0FA)
    else $error("self refresh row cycle too slow");
  refresh_due_a: assert property (init_done && pins.self_refresh_request_n |-> gap_reg < 12'hC80)
    else $error("refresh overdue");
  self_block_a: assert property (self_refresh_active |-> !req_ready)
    else $error("request taken in self refresh");
endmodule : drc_ctrl_chk
bind drc_ctrl drc_ctrl_chk u_chk (.ref_clk(ref_clk), .rst(rst), .init_done(init_done),
  .req_ready(req_ready), .self_refresh_active(self_refresh_active), .pins(pins));
`default_nettype wire

// >>> testbench/drc_mem_model.sv
// behavioural one-bit dynamic memory seen at the controller pins
`timescale 1ns/100ps
`default_nettype none
module drc_mem_model #(
  parameter int ACC_NS = 90
) (
  input  wire drc_pkg::drc_pins_type pins,
  output logic                       dout
);
  import drc_pkg::*;
  logic       mem [int];
  logic [9:0] row_q;
  logic       pend = 1'h0;
  int         key;
  int         falls = 0;
  int         cbr = 0;
  int         ras_only = 0;
  int         selfr = 0;
  initial dout = 1'h0;
  always @(negedge pins.row_strobe_n) begin
    falls++;
    if (!pins.self_refresh_request_n) selfr++;
    else if (!pins.col_strobe_n) cbr++;
    else begin
      row_q = pins.addr;
      pend = 1'h1;
    end
  end
  always @(negedge pins.col_strobe_n) begin
    if (pend && !pins.row_strobe_n) begin
      pend = 1'h0;
      key = int'({row_q, pins.addr});
      if (!pins.write_strobe_n) mem[key] = pins.data_out;
      else dout <= #(ACC_NS) (mem.exists(key) ? mem[key] : 1'h0);
    end
  end
  // released output flips so a late sample never sees stale data
  always @(posedge pins.col_strobe_n) dout <= ~dout;
  always @(posedge pins.row_strobe_n) begin
    if (pend) ras_only++;
    pend = 1'h0;
  end
endmodule : drc_mem_model
`default_nettype wire

// >>> testbench/tb_dram_refresh_and_access_sequencing.sv
// self-checking bench for the dram refresh and access controller
`timescale 1ns/100ps
`default_nettype none
module tb_dram_refresh_and_access_sequencing;
  import drc_pkg::*;
  logic         ref_clk, rst, req_valid, req_ready, rd_valid, rd_data, q;
  logic         init_done, self_refresh_en, self_refresh_active, mem_data_in;
  drc_req_type  req;
  drc_pins_type pins;
  int           err_total = 0;
  int           samples_checked = 0;
  drc_ctrl dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done), .self_refresh_en(self_refresh_en),
    .self_refresh_active(self_refresh_active), .mem_data_in(mem_data_in), .pins(pins));
  drc_mem_model #(.ACC_NS(90)) m (.pins(pins), .dout(mem_data_in));
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // stall > 0 holds the request in self refresh, then ends self refresh
  task automatic access(input logic wr, input logic [9:0] row, input logic d, input int stall);
    int n = 0;
    @(negedge ref_clk);
    req = '{write: wr, row: row, col: 10'h000, data: d};
    req_valid = 1'h1;
    repeat (stall) begin
      tick(1);
      if (req_ready !== 1'h0) n++;
    end
    if (stall > 0) check("held off", n == 0, 1'h1);
    if (stall > 0) begin
      @(negedge ref_clk);
      self_refresh_en = 1'h0;
    end
    for (n = 0; req_ready !== 1'h1 && n < 9000; n++) tick(1);
    check("taken", req_ready, 1'h1);
    @(negedge ref_clk);
    req_valid = 1'h0;
    for (n = 0; !wr && rd_valid !== 1'h1 && n < 400; n++) tick(1);
    if (!wr) check("answered", rd_valid, 1'h1);
    q = rd_data;
  endtask : access
  task automatic t_powerup;
    int n;
    tick(4990);
    check("quiet", m.falls == 0 && pins.col_strobe_n && pins.self_refresh_request_n, 1'h1);
    for (n = 0; init_done !== 1'h1 && n < 2000; n++) tick(1);
    check("init", init_done === 1'h1 && m.falls >= 8 && m.selfr == 0, 1'h1);
    check("row only", m.ras_only >= 8, 1'h1);
  endtask : t_powerup
  task automatic t_rw;
    logic [9:0] rows [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
    foreach (rows[i]) access(1'h1, rows[i], i[0], 0);
    foreach (rows[i]) begin
      access(1'h0, rows[i], 1'h0, 0);
      check("read", q, i[0]);
    end
  endtask : t_rw
  task automatic t_refresh;
    int r0 = m.cbr + m.ras_only;
    tick(3300);
    check("refresh", m.cbr + m.ras_only > r0, 1'h1);
    access(1'h0, 10'h2AA, 1'h0, 0);
    check("kept", q, 1'h1);
  endtask : t_refresh
  task automatic t_self;
    int n, s0;
    @(negedge ref_clk);
    self_refresh_en = 1'h1;
    for (n = 0; self_refresh_active !== 1'h1 && n < 4000; n++) tick(1);
    s0 = m.selfr;
    tick(2000);
    check("self", self_refresh_active === 1'h1 && m.selfr - s0 >= 7, 1'h1);
    access(1'h0, 10'h3FF, 1'h0, 300);
    check("kept self", q, 1'h1);
  endtask : t_self
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  initial begin
    rst = 1'h1;
    req_valid = 1'h0;
    req = '0;
    self_refresh_en = 1'h0;
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    t_powerup();
    t_rw();
    t_refresh();
    t_self();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
endmodule : tb_dram_refresh_and_access_sequencing
`default_nettype wire
